// >>> fupc_consts.svh
`ifndef FUPC_CONSTS_SVH
`define FUPC_CONSTS_SVH
// register byte offsets on the avalon slave
`define FUPC_OFS_CONTROL   5'h00
`define FUPC_OFS_KEY       5'h04
`define FUPC_OFS_SEC_HIGH  5'h08
`define FUPC_OFS_SEC_LOW   5'h0c
`define FUPC_OFS_STATUS    5'h10
// control register fields
`define FUPC_CTL_START     0
`define FUPC_MODE_ERASE    4'ha
`define FUPC_MODE_LOCK     4'h6
// status register fields
`define FUPC_ST_ERASE      0
`define FUPC_ST_PROG       1
`define FUPC_ST_LOCK       2
`define FUPC_ST_KEY        3
`define FUPC_ST_PROT       4
`define FUPC_ST_RAM2K      5
`define FUPC_ST_REFUSED    6
`define FUPC_ST_START      7
// reset values and key
`define FUPC_RST_BYTE      8'h00
`define FUPC_KEY_VALID     8'ha5
// array geometry
`define FUPC_SECTORS_63K   9'h1f8
`define FUPC_SECTORS_62K   9'h1f0
`define FUPC_BOOT_BASE     16'h0100
// option byte fields
`define FUPC_OPT_VEC_OFF   7
`define FUPC_OPT_PROT_OFF  2
`define FUPC_OPT_WAKE_NRST 0
`define FUPC_OPT_MEM_62K   2'b01
// timing
`define FUPC_CLK_HZ        20000000
`define FUPC_ERASE_MIN_MS  4
`define FUPC_ERASE_STL_MS  10
`define FUPC_PROG_MIN_US   20
`define FUPC_ERASE_MIN_CYC ((`FUPC_ERASE_MIN_MS * `FUPC_CLK_HZ + 999) / 1000)
`define FUPC_ERASE_CYCLES  ((`FUPC_ERASE_STL_MS * `FUPC_CLK_HZ + 999) / 1000)
`define FUPC_PROG_CYCLES   ((`FUPC_PROG_MIN_US * `FUPC_CLK_HZ + 999999) / 1000000)
`endif

// >>> fupc_flash_array_model.sv
`timescale 1ns/1ps
// ****************************************
// flash array behaviour
// ****************************************
module fupc_flash_array_model (
  // clock
  input  wire logic        i_clk,
  // array commands
  input  wire logic        i_erase,
  input  wire logic        i_prog,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  // read data
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:65535];  // blank cells read ff
  logic       erase_q;        // erase edge detect
  initial mem = '{default: 8'hff};
  // a whole sector blanks at once; a program touches one byte only
  always @(posedge i_clk) begin
    erase_q <= i_erase;
    if (i_erase && erase_q !== 1'b1) begin
      for (int i = 0; i < 128; i++) begin
        mem[{i_addr[15:7], 7'(i)}] <= 8'hff;
      end
    end
    if (i_prog) begin
      mem[i_addr] <= i_wdata;
    end
  end
  // array answers combinationally from the address
  assign o_rdata = mem[i_addr];
endmodule

// >>> fupc_flash_ctrl.sv
`timescale 1ns/1ps
`include "fupc_consts.svh"
module fupc_flash_ctrl #(
  parameter int unsigned ERASE_CYCLES = `FUPC_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES  = `FUPC_PROG_CYCLES
) (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  // avalon-mm register slave
  input  wire logic [4:0]          i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  input  wire logic [3:0]          i_avs_byteenable,
  output logic [31:0]              o_avs_readdata,
  output logic                     o_avs_waitrequest,
  // cpu program memory load/store port
  input  wire logic                i_pm_read,
  input  wire logic                i_pm_write,
  input  wire logic [15:0]         i_pm_addr,
  input  wire logic [7:0]          i_pm_wdata,
  output logic [7:0]               o_pm_rdata,
  output logic                     o_pm_ack,
  // cpu control
  output logic                     o_cpu_stall,
  input  wire logic                i_tool_mode,
  // flash array macro
  output logic                     o_fl_erase,
  output logic                     o_fl_prog,
  output logic                     o_fl_read,
  output logic [15:0]              o_fl_addr,
  output logic [7:0]               o_fl_wdata,
  input  wire logic [7:0]          i_fl_rdata,
  // boot option bytes
  input  wire logic [7:0]          i_opt_3e,
  input  wire logic [7:0]          i_opt_3f,
  output logic [15:0]              o_reset_vector,
  output logic                     o_ram_2k,
  // stop mode wake
  input  wire logic [7:0]          i_wake_port_a,
  input  wire logic [7:0]          i_wake_port_b,
  input  wire logic                i_stop_mode,
  input  wire logic                i_ext_int_en,
  output logic                     o_stop_release,
  output logic                     o_wake_reset
);
  // ****************************************
  // elaboration checks
  // ****************************************
  // counter is 24 bits wide
  if (ERASE_CYCLES < 1 || ERASE_CYCLES > 32'h00ff_ffff) begin : g_bad_erase
    $error("erase cycle count out of range");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES > 32'h00ff_ffff) begin : g_bad_prog
    $error("program cycle count out of range");
  end

  // ****************************************
  // declarations
  // ****************************************
  fupc_pkg::fupc_state_e state_q;  // sequencer state
  logic [23:0]           cnt_q;    // busy countdown
  logic [7:0]            ctl_q;    // flash_op_control
  logic [7:0]            key_q;    // user_prog_key
  logic [7:0]            sec_hi_q; // sector_addr_high
  logic [7:0]            sec_lo_q; // sector_addr_low
  logic                  lock_q;   // hard lock, sticky to reset
  logic                  refused_q;// dropped request seen
  logic                  stall_q;  // cpu halt
  logic                  ack_q;    // pm answer pulse
  logic [7:0]            rdata_q;  // pm read data
  logic                  wait_q;   // avalon waitrequest
  logic [31:0]           rd_q;     // avalon read data
  logic [7:0]            pa_q;     // previous wake port a
  logic [7:0]            pb_q;     // previous wake port b
  logic                  rel_q;    // stop release pulse
  logic                  wrst_q;   // wake reset pulse
  logic                  erase_q;  // array erase level
  logic                  prog_q;   // array program level
  logic                  fread_q;  // array read level
  logic [15:0]           faddr_q;  // array address
  logic [7:0]            fwd_q;    // array write data
  // decoded options
  logic [15:0]           opt_vec;
  logic                  opt_prot;
  logic [15:0]           opt_end;
  logic                  opt_ram2k;
  logic                  opt_wrst;
  // decode helpers
  logic                  acc;        // avalon access commits
  logic                  ctl_wr;     // control write commits
  logic                  key_ok;     // key unlocks user mode
  logic [8:0]            sec_limit;  // sectors in array
  logic [15:0]           sec_base;   // erase target base
  logic                  erase_req;  // start written with erase mode
  logic                  erase_go;   // erase launches
  logic                  erase_drop; // erase dropped, refused flag set
  logic                  lock_go;    // hard lock taken
  logic                  pm_take;    // pm request may be taken
  logic                  prog_go;    // byte program starts
  logic                  prog_drop;  // byte program dropped
  logic                  done;       // countdown at end
  logic                  wake_edge;  // any wake pin toggled

  // ****************************************
  // option latch
  // ****************************************
  fupc_opt_latch u_opt (
    .i_sys_clk        (i_sys_clk),
    .i_rst_n          (i_rst_n),
    .i_opt_3e         (i_opt_3e),
    .i_opt_3f         (i_opt_3f),
    .o_reset_vector_q (opt_vec),
    .o_prot_en_q      (opt_prot),
    .o_prot_end_q     (opt_end),
    .o_ram_2k_q       (opt_ram2k),
    .o_wake_rst_q     (opt_wrst)
  );

  // ****************************************
  // request decode
  // ****************************************
  assign acc    = (i_avs_read || i_avs_write) && !wait_q;
  // control register dead in tool mode
  assign ctl_wr = acc && i_avs_write && i_avs_byteenable[0] && !i_tool_mode &&
                  (i_avs_address == `FUPC_OFS_CONTROL);
  assign key_ok = (key_q == `FUPC_KEY_VALID);
  // 62K option shrinks the array
  assign sec_limit = opt_ram2k ? `FUPC_SECTORS_62K : `FUPC_SECTORS_63K;
  // low seven sector bits do not matter
  assign sec_base  = {sec_hi_q, sec_lo_q[7], 7'h00};
  assign erase_req = ctl_wr && i_avs_writedata[`FUPC_CTL_START] &&
                     (i_avs_writedata[7:4] == `FUPC_MODE_ERASE) &&
                     (state_q == fupc_pkg::FUPC_IDLE);
  // bad key: no erase and no refused flag, but the control byte is still written and start stays set
  assign erase_drop = erase_req && key_ok &&
                      (lock_q || ({sec_hi_q, sec_lo_q[7]} >= sec_limit) ||
                       fupc_pkg::fupc_in_prot(sec_base, opt_prot, opt_end));
  assign erase_go   = erase_req && key_ok && !erase_drop;
  assign lock_go    = ctl_wr && i_avs_writedata[`FUPC_CTL_START] && key_ok &&
                      (i_avs_writedata[7:4] == `FUPC_MODE_LOCK) &&
                      (state_q == fupc_pkg::FUPC_IDLE);
  // no retake in the cycle the answer shows
  assign pm_take = (state_q == fupc_pkg::FUPC_IDLE) && !ack_q && !erase_go;
  // tool mode programs without key or guard
  assign prog_drop = pm_take && i_pm_write && !i_tool_mode &&
                     (!key_ok || lock_q ||
                      fupc_pkg::fupc_in_prot(i_pm_addr, opt_prot, opt_end));
  assign prog_go   = pm_take && i_pm_write && !prog_drop &&
                     (i_pm_addr[15:7] < sec_limit);
  assign done      = (cnt_q == 24'h00_0000);
  assign wake_edge = |((i_wake_port_a ^ pa_q) | (i_wake_port_b ^ pb_q));

  // ****************************************
  // avalon handshake
  // ****************************************
  // waitrequest drops for exactly one cycle per access
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((i_avs_read || i_avs_write) && wait_q);
    end
  end

  // read data captured as waitrequest falls
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rd_q <= 32'h0000_0000;
    end else if (i_avs_read && wait_q) begin
      case (i_avs_address)
        `FUPC_OFS_CONTROL:  rd_q <= {24'h00_0000, ctl_q};
        `FUPC_OFS_KEY:      rd_q <= {24'h00_0000, key_q};
        `FUPC_OFS_SEC_HIGH: rd_q <= {24'h00_0000, sec_hi_q};
        `FUPC_OFS_SEC_LOW:  rd_q <= {24'h00_0000, sec_lo_q};
        `FUPC_OFS_STATUS: begin
          rd_q <= {24'h00_0000, ctl_q[`FUPC_CTL_START], refused_q, opt_ram2k,
                   opt_prot, key_ok, lock_q, state_q == fupc_pkg::FUPC_PROG,
                   state_q == fupc_pkg::FUPC_ERASE};
        end
        // unmapped reads answer zero
        default:            rd_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  // key and sector address, low byte lane only
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      key_q    <= `FUPC_RST_BYTE;
      sec_hi_q <= `FUPC_RST_BYTE;
      sec_lo_q <= `FUPC_RST_BYTE;
    end else if (acc && i_avs_write && i_avs_byteenable[0]) begin
      case (i_avs_address)
        `FUPC_OFS_KEY:      key_q    <= i_avs_writedata[7:0];
        `FUPC_OFS_SEC_HIGH: sec_hi_q <= i_avs_writedata[7:0];
        `FUPC_OFS_SEC_LOW:  sec_lo_q <= i_avs_writedata[7:0];
        default: begin
          // other offsets leave these alone
        end
      endcase
    end
  end

  // control register with self-clearing start bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctl_q <= `FUPC_RST_BYTE;
    end else if (ctl_wr) begin
      ctl_q <= i_avs_writedata[7:0];
      // lock and dropped erase finish at once
      if (lock_go || erase_drop) begin
        ctl_q[`FUPC_CTL_START] <= 1'b0;
      end
    end else if (state_q == fupc_pkg::FUPC_ERASE && done) begin
      ctl_q[`FUPC_CTL_START] <= 1'b0;
    end
  end

  // hard lock holds until reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lock_q <= 1'b0;
    end else if (lock_go) begin
      lock_q <= 1'b1;
    end
  end

  // refused flag, write one to clear, set wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      refused_q <= 1'b0;
    end else if (erase_drop || prog_drop) begin
      refused_q <= 1'b1;
    end else if (acc && i_avs_write && i_avs_byteenable[0] &&
                 (i_avs_address == `FUPC_OFS_STATUS) &&
                 i_avs_writedata[`FUPC_ST_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // one sector or one byte per operation
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= fupc_pkg::FUPC_IDLE;
      cnt_q   <= 24'h00_0000;
    end else begin
      case (state_q)
        fupc_pkg::FUPC_IDLE: begin
          if (erase_go) begin
            state_q <= fupc_pkg::FUPC_ERASE;
            cnt_q   <= 24'(ERASE_CYCLES - 1);
          end else if (prog_go) begin
            state_q <= fupc_pkg::FUPC_PROG;
            cnt_q   <= 24'(PROG_CYCLES - 1);
          end else if (pm_take && i_pm_read) begin
            state_q <= fupc_pkg::FUPC_READ;
          end
        end
        fupc_pkg::FUPC_ERASE, fupc_pkg::FUPC_PROG: begin
          // busy until the count runs out
          if (done) begin
            state_q <= fupc_pkg::FUPC_IDLE;
          end else begin
            cnt_q <= cnt_q - 24'h00_0001;
          end
        end
        fupc_pkg::FUPC_READ: begin
          state_q <= fupc_pkg::FUPC_IDLE;
        end
        default: begin
          state_q <= fupc_pkg::FUPC_IDLE;
        end
      endcase
    end
  end

  // cpu halt during erase, released by hardware
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      stall_q <= 1'b0;
    end else if (erase_go) begin
      stall_q <= 1'b1;
    end else if (state_q == fupc_pkg::FUPC_ERASE && done) begin
      stall_q <= 1'b0;
    end
  end

  // pm answer: after program, read, or drop
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= prog_drop ||
               (pm_take && i_pm_write && !prog_drop && !prog_go) ||
               (state_q == fupc_pkg::FUPC_PROG && done) ||
               (state_q == fupc_pkg::FUPC_READ);
      if (state_q == fupc_pkg::FUPC_READ) begin
        rdata_q <= i_fl_rdata;
      end
    end
  end

  // array strobes, held for the whole operation
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      erase_q <= 1'b0;
      prog_q  <= 1'b0;
      fread_q <= 1'b0;
      faddr_q <= 16'h0000;
      fwd_q   <= 8'h00;
    end else begin
      erase_q <= erase_go || (state_q == fupc_pkg::FUPC_ERASE && !done);
      prog_q  <= prog_go  || (state_q == fupc_pkg::FUPC_PROG && !done);
      fread_q <= pm_take && i_pm_read && !i_pm_write;
      if (erase_go) begin
        faddr_q <= sec_base;
      end else if (pm_take && (i_pm_write || i_pm_read)) begin
        faddr_q <= i_pm_addr;
        fwd_q   <= i_pm_wdata;
      end
    end
  end

  // ****************************************
  // stop mode wake
  // ****************************************
  // pins tracked in reset too: no false edge at release
  always_ff @(posedge i_sys_clk) begin
    pa_q <= i_wake_port_a;
    pb_q <= i_wake_port_b;
    if (!i_rst_n) begin
      rel_q  <= 1'b0;
      wrst_q <= 1'b0;
    end else begin
      rel_q  <= i_stop_mode && i_ext_int_en && wake_edge;
      wrst_q <= i_stop_mode && i_ext_int_en && wake_edge && opt_wrst;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_avs_readdata    = rd_q;
  assign o_avs_waitrequest = wait_q;
  assign o_pm_rdata        = rdata_q;
  assign o_pm_ack          = ack_q;
  assign o_cpu_stall       = stall_q;
  assign o_fl_erase        = erase_q;
  assign o_fl_prog         = prog_q;
  assign o_fl_read         = fread_q;
  assign o_fl_addr         = faddr_q;
  assign o_fl_wdata        = fwd_q;
  assign o_reset_vector    = opt_vec;
  assign o_ram_2k          = opt_ram2k;
  assign o_stop_release    = rel_q;
  assign o_wake_reset      = wrst_q;
endmodule

// >>> fupc_flash_ctrl_props.sv
`timescale 1ns/1ps
// ****************************************
// flash sequencer port checker
// ****************************************
module fupc_flash_ctrl_props #(
  parameter int unsigned ERASE_CYCLES = 20,
  parameter int unsigned PROG_CYCLES  = 5
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // register bus
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic        o_avs_waitrequest,
  // program memory and array
  input  wire logic        i_tool_mode,
  input  wire logic [7:0]  o_pm_rdata,
  input  wire logic        o_pm_ack,
  input  wire logic        o_cpu_stall,
  input  wire logic        o_fl_erase,
  input  wire logic        o_fl_prog,
  input  wire logic        o_fl_read,
  input  wire logic [15:0] o_fl_addr,
  input  wire logic [7:0]  i_fl_rdata,
  // options and wake
  input  wire logic [7:0]  i_opt_3e,
  input  wire logic [7:0]  i_opt_3f,
  input  wire logic [15:0] o_reset_vector,
  input  wire logic        o_ram_2k,
  input  wire logic [7:0]  i_wake_port_a,
  input  wire logic [7:0]  i_wake_port_b,
  input  wire logic        i_stop_mode,
  input  wire logic        i_ext_int_en,
  input  wire logic        o_stop_release,
  input  wire logic        o_wake_reset
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0]  e_q;     // option byte 3e as held in reset
  logic [7:0]  f_q;     // option byte 3f as held in reset
  logic [31:0] ecnt_q;  // erase run length
  logic [31:0] pcnt_q;  // program run length
  logic [15:0] lim;     // first address past guarded area
  logic [15:0] vec;     // expected reset vector
  // shadow the option latch: last bytes seen in reset win
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      e_q <= i_opt_3e;
      f_q <= i_opt_3f;
    end
  end
  // count run lengths so long pulses need no repetition operator
  always_ff @(posedge i_sys_clk) begin
    ecnt_q <= (i_rst_n && o_fl_erase) ? ecnt_q + 1 : 32'h0000_0000;
    pcnt_q <= (i_rst_n && o_fl_prog) ? pcnt_q + 1 : 32'h0000_0000;
  end
  assign lim = 16'h0100 + (16'h0100 << e_q[1:0]);
  assign vec = e_q[7] ? 16'h0100 : 16'h0100 + (16'h0100 << e_q[6:5]);

  a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("waitrequest not one cycle");
  a_stall_covers_erase: assert property (o_fl_erase |-> o_cpu_stall)
    else $error("cpu not stalled in erase");
  a_stall_auto_resume: assert property ($fell(o_fl_erase) |-> $fell(o_cpu_stall))
    else $error("stall not released with erase end");
  a_erase_time_min: assert property ($fell(o_fl_erase) |-> ecnt_q == ERASE_CYCLES)
    else $error("erase length wrong");
  a_prog_time_ack: assert property ($fell(o_fl_prog) |-> pcnt_q == PROG_CYCLES && o_pm_ack)
    else $error("program length or ack wrong");
  a_sector_base_only: assert property (o_fl_erase |-> o_fl_addr[6:0] == 7'h00)
    else $error("erase address not sector base");
  a_boot_area_guard: assert property (o_fl_prog && !i_tool_mode && !e_q[2]
    |-> !(o_fl_addr >= 16'h0100 && o_fl_addr < lim)) else $error("guarded byte written");
  a_read_data_path: assert property (o_fl_read |=> o_pm_ack && o_pm_rdata == $past(i_fl_rdata))
    else $error("read data wrong");
  a_option_decode: assert property ($past(i_rst_n) |-> o_reset_vector == vec
    && o_ram_2k == (f_q[7:6] == 2'b01)) else $error("option decode wrong");
  a_wake_pulse_out: assert property (i_stop_mode && i_ext_int_en &&
    (i_wake_port_a != $past(i_wake_port_a) || i_wake_port_b != $past(i_wake_port_b))
    |=> o_stop_release && o_wake_reset == !f_q[0]) else $error("wake pulse wrong");
  c_erase_done: cover property ($fell(o_fl_erase));
  c_prog_done: cover property ($fell(o_fl_prog));
  c_wake_seen: cover property (o_stop_release);
endmodule

bind fupc_flash_ctrl fupc_flash_ctrl_props #(
  .ERASE_CYCLES (ERASE_CYCLES),
  .PROG_CYCLES  (PROG_CYCLES)
) u_props (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .i_tool_mode(i_tool_mode), .o_pm_rdata(o_pm_rdata), .o_pm_ack(o_pm_ack),
  .o_cpu_stall(o_cpu_stall), .o_fl_erase(o_fl_erase), .o_fl_prog(o_fl_prog),
  .o_fl_read(o_fl_read), .o_fl_addr(o_fl_addr), .i_fl_rdata(i_fl_rdata),
  .i_opt_3e(i_opt_3e), .i_opt_3f(i_opt_3f), .o_reset_vector(o_reset_vector),
  .o_ram_2k(o_ram_2k), .i_wake_port_a(i_wake_port_a), .i_wake_port_b(i_wake_port_b),
  .i_stop_mode(i_stop_mode), .i_ext_int_en(i_ext_int_en),
  .o_stop_release(o_stop_release), .o_wake_reset(o_wake_reset)
);

// >>> fupc_opt_latch.sv
`timescale 1ns/1ps
`include "fupc_consts.svh"
// ****************************************
// boot option latch and decode
// ****************************************
module fupc_opt_latch (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  // option bytes from program memory
  input  wire logic [7:0]          i_opt_3e,
  input  wire logic [7:0]          i_opt_3f,
  // decoded settings
  output logic [15:0]              o_reset_vector_q,
  output logic                     o_prot_en_q,
  output logic [15:0]              o_prot_end_q,
  output logic                     o_ram_2k_q,
  output logic                     o_wake_rst_q
);
  // sampled while reset is held, frozen after release
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      // vector field alone picks the entry point
      if (i_opt_3e[`FUPC_OPT_VEC_OFF]) begin
        o_reset_vector_q <= `FUPC_BOOT_BASE;
      end else begin
        o_reset_vector_q <= fupc_pkg::fupc_area_end(i_opt_3e[6:5]);
      end
      // protection field decoded on its own
      o_prot_en_q  <= ~i_opt_3e[`FUPC_OPT_PROT_OFF];
      o_prot_end_q <= fupc_pkg::fupc_area_end(i_opt_3e[1:0]);
      o_ram_2k_q   <= (i_opt_3f[7:6] == `FUPC_OPT_MEM_62K);
      o_wake_rst_q <= ~i_opt_3f[`FUPC_OPT_WAKE_NRST];
    end
  end
endmodule

// >>> fupc_pkg.sv
package fupc_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    FUPC_IDLE  = 2'b00,
    FUPC_ERASE = 2'b01,
    FUPC_PROG  = 2'b10,
    FUPC_READ  = 2'b11
  } fupc_state_e;

  typedef logic [15:0] fupc_addr_t;

  // first address past a boot area of the given size code
  function automatic fupc_addr_t fupc_area_end(input logic [1:0] sel);
    case (sel)
      2'b00:   fupc_area_end = 16'h0200;
      2'b01:   fupc_area_end = 16'h0300;
      2'b10:   fupc_area_end = 16'h0500;
      default: fupc_area_end = 16'h0900;
    endcase
  endfunction

  // address falls in the guarded boot area
  function automatic logic fupc_in_prot(input fupc_addr_t a, input logic en,
                                        input fupc_addr_t lim);
    fupc_in_prot = en && (a >= 16'h0100) && (a < lim);
  endfunction
endpackage

// >>> test_flash_user_program_control.sv
`timescale 1ns/1ps
`include "fupc_consts.svh"
// ****************************************
// flash sequencer testbench
// ****************************************
module test_flash_user_program_control;
  logic        clk = 0, rst_n = 0, av_rd = 0, av_wr = 0, pm_rd = 0, pm_wr = 0;
  logic        tool = 0, stop = 0, int_en = 0, av_wait, pm_ack, stall;
  logic        fl_erase, fl_prog, fl_read, ram2k, rel, wrst;
  logic [4:0]  av_addr = 5'h00;
  logic [31:0] av_wd = 32'h0000_0000, av_rdata, q;
  logic [15:0] pm_addr = 16'h0000, fl_addr, vec;
  logic [7:0]  pm_wd = 8'h00, pm_rdata, fl_wdata, fl_rdata, wake_a = 8'h00, wake_b = 8'h00;
  logic [7:0]  opt_3e = 8'h00, opt_3f = 8'h00;
  int          err_count = 0, num_checks = 0, cycles = 0;
  logic [7:0]  e_tab [6] = '{8'h80, 8'h00, 8'h20, 8'h40, 8'h60, 8'hff};
  logic [15:0] v_tab [6] = '{16'h0100, 16'h0200, 16'h0300, 16'h0500, 16'h0900, 16'h0100};

  // short counts keep the erase run brief
  fupc_flash_ctrl #(.ERASE_CYCLES(20), .PROG_CYCLES(5)) dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(av_addr), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_pm_read(pm_rd),
    .i_pm_write(pm_wr), .i_pm_addr(pm_addr), .i_pm_wdata(pm_wd), .o_pm_rdata(pm_rdata),
    .o_pm_ack(pm_ack), .o_cpu_stall(stall), .i_tool_mode(tool), .o_fl_erase(fl_erase),
    .o_fl_prog(fl_prog), .o_fl_read(fl_read), .o_fl_addr(fl_addr), .o_fl_wdata(fl_wdata),
    .i_fl_rdata(fl_rdata), .i_opt_3e(opt_3e), .i_opt_3f(opt_3f), .o_reset_vector(vec),
    .o_ram_2k(ram2k), .i_wake_port_a(wake_a), .i_wake_port_b(wake_b), .i_stop_mode(stop),
    .i_ext_int_en(int_en), .o_stop_release(rel), .o_wake_reset(wrst));
  fupc_flash_array_model u_array (.i_clk(clk), .i_erase(fl_erase), .i_prog(fl_prog),
    .i_addr(fl_addr), .i_wdata(fl_wdata), .o_rdata(fl_rdata));

  always #25 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      end_of_test;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // register access held until waitrequest low
  task automatic av(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    av_addr <= a;
    av_wd <= {24'h00_0000, d};
    av_wr <= wr;
    av_rd <= !wr;
    do @(posedge clk); while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  // cpu load/store held until ack
  task automatic pm(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    pm_addr <= a;
    pm_wd <= d;
    pm_wr <= wr;
    pm_rd <= !wr;
    do @(posedge clk); while (pm_ack !== 1'b1);
    q = {24'h00_0000, pm_rdata};
    pm_wr <= 1'b0;
    pm_rd <= 1'b0;
  endtask
  task automatic rst(input logic [7:0] e, input logic [7:0] f);
    @(posedge clk);
    rst_n <= 1'b0;
    opt_3e <= e;
    opt_3f <= f;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic end_of_test;
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    // every vector code and both memory sizes
    for (int i = 0; i < 6; i++) begin
      rst(e_tab[i], i[0] ? 8'hff : 8'h40);
      chk("vector", vec, v_tab[i]);
      chk("ram2k", ram2k, !i[0]);
    end
    // guarded 256-byte area, wake also resets
    rst(8'h00, 8'hfe);
    av(0, `FUPC_OFS_KEY, 8'h00);
    chk("key", q, 32'h0000_0000);
    av(1, `FUPC_OFS_CONTROL, 8'ha1);
    av(0, `FUPC_OFS_STATUS, 8'h00);
    chk("stuck start", q & 32'h0000_0081, 32'h0000_0080);
    av(1, `FUPC_OFS_CONTROL, 8'h00);
    av(1, `FUPC_OFS_KEY, 8'ha5);
    pm(1, 16'h4005, 8'h5a);
    pm(1, 16'h4085, 8'h33);
    pm(0, 16'h4005, 8'h00);
    chk("program", q, 32'h0000_005a);
    pm(1, 16'h0150, 8'h11);
    pm(0, 16'h0150, 8'h00);
    chk("guarded", q, 32'h0000_00ff);
    // erase sector at 4000h
    av(1, `FUPC_OFS_SEC_HIGH, 8'h40);
    av(1, `FUPC_OFS_SEC_LOW, 8'h00);
    av(1, `FUPC_OFS_CONTROL, 8'ha1);
    @(negedge clk);
    chk("stall", stall, 1'b1);
    while (stall !== 1'b0) @(negedge clk);
    av(0, `FUPC_OFS_CONTROL, 8'h00);
    chk("start clear", q[0], 1'b0);
    av(1, `FUPC_OFS_KEY, 8'h00);
    pm(0, 16'h4005, 8'h00);
    chk("erased", q, 32'h0000_00ff);
    pm(0, 16'h4085, 8'h00);
    chk("next sector", q, 32'h0000_0033);
    // tool mode passes the guard
    tool <= 1'b1;
    pm(1, 16'h0150, 8'h22);
    pm(0, 16'h0150, 8'h00);
    chk("tool", q, 32'h0000_0022);
    tool <= 1'b0;
    // wake from stop
    stop <= 1'b1;
    int_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      {wake_a, wake_b} <= k ? 16'h8004 : 16'h8000;
      do @(posedge clk); while (rel !== 1'b1);
      chk("wake reset", wrst, 1'b1);
    end
    stop <= 1'b0;
    // hard lock blocks later stores
    av(1, `FUPC_OFS_KEY, 8'ha5);
    av(1, `FUPC_OFS_CONTROL, 8'h61);
    av(0, `FUPC_OFS_STATUS, 8'h00);
    chk("lock", q[2], 1'b1);
    pm(1, 16'h4020, 8'h77);
    pm(0, 16'h4020, 8'h00);
    chk("locked", q, 32'h0000_00ff);
    end_of_test;
  end
endmodule
